/* File: logic/esi_top.sv */
// channel status indicators: track, fault, supply, latch, gate, run and diag leds
`timescale 1ns/1ps
// Summary of operation
// R1 - track green follows sampled true level; the code blanks green on any track that shows red
// R2 - track red only on enabled broken wire
// R3 - wire-break diagnosis only in differential types
// R4 - each track needs its own detection enable
// R5 - encoder pulls fault low; idles high
// R6 - status red while encoder fault asserted
// R7 - status off when no fault reported
// R8 - supply green while encoder supply present
// R9 - latch green while latch input active
// R10 - gate green while gate input active
// R11 - run off in init or firmware update
// R12 - run flashes in pre-operational state
// R13 - run single flash in safe-operational
// R14 - outputs held safe in safe-operational
// R15 - run steady on in operational state
// R16 - diag red during init process or boot
// R17 - counter modes take direction from B
// R18 - single-ended modes ignore inverse inputs
// R19 - patterns come from divided system clock
// R20 - channel 2 uses own type and enables
module esi_top #(
  parameter int unsigned FLASH_CYCLES = esi_pkg::FLASH_CYCLES
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic track_a_input,
  input wire logic track_b_input,
  input wire logic track_c_zero_pulse_input,
  input wire logic track_a_inverse,
  input wire logic track_b_inverse,
  input wire logic track_c_inverse,
  input wire logic fault_status_n,
  input wire logic encoder_supply_present,
  input wire logic latch_input,
  input wire logic gate_input,
  input wire logic [2:0] ch1_wire_break,
  input wire logic [2:0] ch2_wire_break,
  input wire logic [esi_pkg::TYPE_W-1:0] ch1_input_type,
  input wire logic ch1_err_det_a,
  input wire logic ch1_err_det_b,
  input wire logic ch1_err_det_c,
  input wire logic [esi_pkg::TYPE_W-1:0] ch2_input_type,
  input wire logic ch2_err_det_a,
  input wire logic ch2_err_det_b,
  input wire logic ch2_err_det_c,
  input wire logic [esi_pkg::STATE_W-1:0] slave_state,
  input wire logic init_active,
  output logic [2:0] led_track_green,
  output logic [2:0] led_track_red,
  output logic led_status_red,
  output logic led_supply_green,
  output logic led_latch_green,
  output logic led_gate_green,
  output logic led_run,
  output logic led_diag,
  output logic [2:0] led_ch2_track_red,
  output logic outputs_safe,
  output logic count_dir,
  output logic [2:0] track_level
);

  logic [esi_pkg::SYNC_W-1:0] pins_raw;
  logic [esi_pkg::SYNC_W-1:0] pins_s;
  logic flash_w;
  logic single_w;

  assign pins_raw = {ch2_wire_break, ch1_wire_break, gate_input, latch_input,
                     encoder_supply_present, fault_status_n,
                     track_c_inverse, track_b_inverse, track_a_inverse,
                     track_c_zero_pulse_input, track_b_input, track_a_input};

  // every pin in pins_raw passes two flip-flops before any decode reads it
  esi_sync #(
    .WIDTH(esi_pkg::SYNC_W),
    .RST_VAL(esi_pkg::SYNC_RST)
  ) u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .ce(ce),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  esi_blink #(
    .FLASH_CYCLES(FLASH_CYCLES)
  ) u_blink (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .ce(ce),
    .flash_q(flash_w),
    .single_q(single_w)
  );

  // synchronised pin groups
  wire [2:0] trk_s = pins_s[esi_pkg::BIT_A +: 3];
  wire [2:0] inv_s = pins_s[esi_pkg::BIT_AN +: 3];
  wire fault_s = ~pins_s[esi_pkg::BIT_FAULT_N]; // R5
  wire supply_s = pins_s[esi_pkg::BIT_SUPPLY];
  wire latch_s = pins_s[esi_pkg::BIT_LATCH];
  wire gate_s = pins_s[esi_pkg::BIT_GATE];
  wire [2:0] wb1_s = pins_s[esi_pkg::BIT_WB1 +: 3];
  wire [2:0] wb2_s = pins_s[esi_pkg::BIT_WB2 +: 3];

  // input type decode
  wire ch1_diff = (ch1_input_type == esi_pkg::TYPE_DIFF_ENC) ||
                  (ch1_input_type == esi_pkg::TYPE_DIFF_CNT); // R3
  wire ch2_diff = (ch2_input_type == esi_pkg::TYPE_DIFF_ENC) ||
                  (ch2_input_type == esi_pkg::TYPE_DIFF_CNT); // R20
  wire ch1_counter = (ch1_input_type == esi_pkg::TYPE_DIFF_CNT) ||
                     (ch1_input_type == esi_pkg::TYPE_TTL_CNT) ||
                     (ch1_input_type == esi_pkg::TYPE_OC_CNT);
  wire ch1_single_ended = !ch1_diff;
  wire [2:0] ch1_en = {ch1_err_det_c, ch1_err_det_b, ch1_err_det_a};
  wire [2:0] ch2_en = {ch2_err_det_c, ch2_err_det_b, ch2_err_det_a};

  // a differential pair reads true only when both legs agree; single-ended
  // wiring leaves the inverse pins open, so they must not be looked at
  wire [2:0] level_w = ch1_single_ended ? trk_s : (trk_s & ~inv_s); // R18

  wire [2:0] red1_w = wb1_s & ch1_en & {3{ch1_diff}}; // R2 R3 R4
  wire [2:0] red2_w = wb2_s & ch2_en & {3{ch2_diff}}; // R20

  // a track flagged red for a broken wire shows red only, never a stale green
  wire [2:0] green_w = level_w & ~red1_w; // R1

  // slave state decode
  wire st_idle = (slave_state == esi_pkg::ST_INIT) ||
                 (slave_state == esi_pkg::ST_BOOT);
  wire st_state_pre_operational = (slave_state == esi_pkg::ST_STATE_PRE_OPERATIONAL);
  wire st_state_safe_operational = (slave_state == esi_pkg::ST_STATE_SAFE_OPERATIONAL);
  wire st_op = (slave_state == esi_pkg::ST_OP);
  wire diag_w = init_active || (slave_state == esi_pkg::ST_BOOT); // R16

  esi_pkg::esi_run_type run_mode_q;
  esi_pkg::esi_run_type run_mode_d;

  // unknown state codes fall back to dark, the same as init
  always_comb begin
    run_mode_d = esi_pkg::RUN_OFF; // R11
    if (st_state_pre_operational) begin
      run_mode_d = esi_pkg::RUN_BLINK; // R12
    end else if (st_state_safe_operational) begin
      run_mode_d = esi_pkg::RUN_SINGLE; // R13
    end else if (st_op) begin
      run_mode_d = esi_pkg::RUN_ON; // R15
    end
  end

  logic run_w;
  always_comb begin
    unique case (run_mode_q)
      esi_pkg::RUN_OFF: run_w = 1'b0; // R11
      esi_pkg::RUN_BLINK: run_w = flash_w; // R12
      esi_pkg::RUN_SINGLE: run_w = single_w; // R13
      esi_pkg::RUN_ON: run_w = 1'b1; // R15
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      run_mode_q <= esi_pkg::RUN_OFF;
      led_run <= esi_pkg::LED_RST;
      led_diag <= esi_pkg::LED_RST;
      outputs_safe <= esi_pkg::SAFE_RST;
    end else if (ce) begin
      run_mode_q <= run_mode_d;
      led_run <= run_w;
      led_diag <= diag_w; // R16
      // outputs stay safe until the slave reaches operational
      outputs_safe <= !st_op; // R14
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      led_track_green <= esi_pkg::LED3_RST;
      led_track_red <= esi_pkg::LED3_RST;
      led_ch2_track_red <= esi_pkg::LED3_RST;
      led_status_red <= esi_pkg::LED_RST;
      led_supply_green <= esi_pkg::LED_RST;
      led_latch_green <= esi_pkg::LED_RST;
      led_gate_green <= esi_pkg::LED_RST;
      track_level <= esi_pkg::LED3_RST;
      count_dir <= esi_pkg::DIR_RST;
    end else if (ce) begin
      led_track_green <= green_w; // R1
      led_track_red <= red1_w; // R2
      led_ch2_track_red <= red2_w; // R20
      led_status_red <= fault_s; // R6 R7
      led_supply_green <= supply_s; // R8
      led_latch_green <= latch_s; // R9
      led_gate_green <= gate_s; // R10
      track_level <= level_w; // R18
      // encoder modes leave direction to the quadrature decoder
      count_dir <= ch1_counter ? level_w[1] : 1'b0; // R17
    end
  end

  // checks

  // three cycles: the mode register may still hold its reset value on the first
  sequence s_idle3;
    (ce && st_idle) [*3];
  endsequence

  sequence s_op3;
    (ce && st_op) [*3];
  endsequence

  sequence s_preop3;
    (ce && st_state_pre_operational) [*3];
  endsequence

  sequence s_safeop3;
    (ce && st_state_safe_operational) [*3];
  endsequence

  property p_green_level;
    @(posedge mclk) disable iff (sys_rst)
      ce |=> (led_track_green == ($past(level_w) & ~$past(red1_w)));
  endproperty
  a_green_level: assert property (p_green_level) else $error("track green does not follow level"); // R1

  property p_red_needs_diff;
    @(posedge mclk) disable iff (sys_rst)
      (ce && !ch1_diff) |=> (led_track_red == 3'h0);
  endproperty
  a_red_needs_diff: assert property (p_red_needs_diff) else $error("red shown in single-ended mode"); // R3

  property p_red_needs_enable;
    @(posedge mclk) disable iff (sys_rst)
      (ce && !ch1_err_det_b) |=> !led_track_red[1];
  endproperty
  a_red_needs_enable: assert property (p_red_needs_enable) else $error("red on track b without enable"); // R4

  property p_red_on_break;
    @(posedge mclk) disable iff (sys_rst)
      (ce && ch1_diff && ch1_err_det_a && wb1_s[0]) |=> (led_track_red[0] && !led_track_green[0]);
  endproperty
  a_red_on_break: assert property (p_red_on_break) else $error("broken wire not shown red"); // R2

  property p_status_fault;
    @(posedge mclk) disable iff (sys_rst)
      ce |=> (led_status_red == !$past(pins_s[esi_pkg::BIT_FAULT_N]));
  endproperty
  a_status_fault: assert property (p_status_fault) else $error("status led disagrees with fault pin"); // R6

  property p_gate_latch;
    @(posedge mclk) disable iff (sys_rst)
      (ce && gate_s && !latch_s) |=> (led_gate_green && !led_latch_green);
  endproperty
  a_gate_latch: assert property (p_gate_latch) else $error("gate or latch led wrong"); // R10

  property p_run_off;
    @(posedge mclk) disable iff (sys_rst)
      s_idle3 |=> !led_run;
  endproperty
  a_run_off: assert property (p_run_off) else $error("run led lit in init or boot"); // R11

  property p_run_on;
    @(posedge mclk) disable iff (sys_rst)
      s_op3 |=> (led_run && !outputs_safe);
  endproperty
  a_run_on: assert property (p_run_on) else $error("run led not steady in operational"); // R15

  property p_run_flash;
    @(posedge mclk) disable iff (sys_rst)
      s_preop3 |=> (led_run == $past(flash_w));
  endproperty
  a_run_flash: assert property (p_run_flash) else $error("run led not flashing in pre-operational"); // R12

  property p_safe;
    @(posedge mclk) disable iff (sys_rst)
      (ce && st_state_safe_operational) |=> outputs_safe;
  endproperty
  a_safe: assert property (p_safe) else $error("outputs not safe in safe-operational"); // R14

  property p_diag;
    @(posedge mclk) disable iff (sys_rst)
      (ce && init_active) |=> led_diag;
  endproperty
  a_diag: assert property (p_diag) else $error("diag led dark during init"); // R16

  property p_dir;
    @(posedge mclk) disable iff (sys_rst)
      (ce && ch1_counter) |=> (count_dir == $past(level_w[1]));
  endproperty
  a_dir: assert property (p_dir) else $error("count direction not from track b"); // R17

  property p_ignore_inverse;
    @(posedge mclk) disable iff (sys_rst)
      (ce && ch1_single_ended) |=> (track_level == $past(trk_s));
  endproperty
  a_ignore_inverse: assert property (p_ignore_inverse) else $error("inverse input used in single-ended mode"); // R18

  property p_ch2_gate;
    @(posedge mclk) disable iff (sys_rst)
      (ce && (!ch2_diff || !ch2_err_det_a)) |=> !led_ch2_track_red[0];
  endproperty
  a_ch2_gate: assert property (p_ch2_gate) else $error("channel 2 red without its own enable"); // R20

  property p_supply;
    @(posedge mclk) disable iff (sys_rst)
      ce |=> (led_supply_green == $past(supply_s));
  endproperty
  a_supply: assert property (p_supply) else $error("supply led disagrees with supply pin"); // R8

  property p_run_single;
    @(posedge mclk) disable iff (sys_rst)
      s_safeop3 |=> (led_run == $past(single_w));
  endproperty
  a_run_single: assert property (p_run_single) else $error("run led not single flash in safe-operational"); // R13

  property p_status_clear;
    @(posedge mclk) disable iff (sys_rst)
      (ce && !fault_s) |=> !led_status_red;
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("status led lit without fault"); // R7

  property p_latch;
    @(posedge mclk) disable iff (sys_rst)
      ce |=> (led_latch_green == $past(latch_s));
  endproperty
  a_latch: assert property (p_latch) else $error("latch led disagrees with latch pin"); // R9

  property p_red_c_enable;
    @(posedge mclk) disable iff (sys_rst)
      (ce && !ch1_err_det_c) |=> !led_track_red[2];
  endproperty
  a_red_c_enable: assert property (p_red_c_enable) else $error("red on track c without enable"); // R4

  property p_ch2_red_on_break;
    @(posedge mclk) disable iff (sys_rst)
      (ce && ch2_diff && ch2_err_det_b && wb2_s[1]) |=> led_ch2_track_red[1];
  endproperty
  a_ch2_red_on_break: assert property (p_ch2_red_on_break) else $error("channel 2 broken wire not shown red"); // R20

  property p_diag_boot;
    @(posedge mclk) disable iff (sys_rst)
      (ce && (slave_state == esi_pkg::ST_BOOT)) |=> led_diag;
  endproperty
  a_diag_boot: assert property (p_diag_boot) else $error("diag led dark in boot"); // R16

  property p_dir_encoder;
    @(posedge mclk) disable iff (sys_rst)
      (ce && !ch1_counter) |=> !count_dir;
  endproperty
  a_dir_encoder: assert property (p_dir_encoder) else $error("count direction set in encoder mode"); // R17

endmodule

/* File: logic/esi_pkg.sv */
// shared constants and types for the encoder status indicator block
package esi_pkg;

  // system clock and indicator pattern timing
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned FLASH_MS = 200;
  localparam int unsigned FLASH_CYCLES = CLK_HZ / 1000 * FLASH_MS;
  // single flash: one phase lit, five phases dark
  localparam int unsigned SINGLE_PHASES = 6;
  localparam int unsigned PHASE_W = 3;
  localparam logic [PHASE_W-1:0] PHASE_LAST = 3'h5;
  localparam logic [PHASE_W-1:0] PHASE_RST = 3'h0;

  // input type setting of a channel
  localparam int unsigned TYPE_W = 3;
  localparam logic [TYPE_W-1:0] TYPE_DIFF_ENC = 3'h0;
  localparam logic [TYPE_W-1:0] TYPE_DIFF_CNT = 3'h1;
  localparam logic [TYPE_W-1:0] TYPE_TTL_ENC = 3'h2;
  localparam logic [TYPE_W-1:0] TYPE_TTL_CNT = 3'h3;
  localparam logic [TYPE_W-1:0] TYPE_OC_ENC = 3'h4;
  localparam logic [TYPE_W-1:0] TYPE_OC_CNT = 3'h5;

  // slave state machine codes
  localparam int unsigned STATE_W = 4;
  localparam logic [STATE_W-1:0] ST_INIT = 4'h1;
  localparam logic [STATE_W-1:0] ST_STATE_PRE_OPERATIONAL = 4'h2;
  localparam logic [STATE_W-1:0] ST_BOOT = 4'h3;
  localparam logic [STATE_W-1:0] ST_STATE_SAFE_OPERATIONAL = 4'h4;
  localparam logic [STATE_W-1:0] ST_OP = 4'h8;

  // positions in the synchronised pin vector
  localparam int unsigned SYNC_W = 16;
  localparam int unsigned BIT_A = 0;
  localparam int unsigned BIT_AN = 3;
  localparam int unsigned BIT_FAULT_N = 6;
  localparam int unsigned BIT_SUPPLY = 7;
  localparam int unsigned BIT_LATCH = 8;
  localparam int unsigned BIT_GATE = 9;
  localparam int unsigned BIT_WB1 = 10;
  localparam int unsigned BIT_WB2 = 13;
  // fault pin idles high, so its stages reset high
  localparam logic [SYNC_W-1:0] SYNC_RST = 16'h0040;

  localparam logic [2:0] LED3_RST = 3'h0;
  localparam logic LED_RST = 1'b0;
  localparam logic SAFE_RST = 1'b1;
  localparam logic DIR_RST = 1'b0;
  localparam logic PATTERN_RST = 1'b1;

  typedef enum logic [1:0] {
    RUN_OFF = 2'b00,
    RUN_BLINK = 2'b01,
    RUN_SINGLE = 2'b11,
    RUN_ON = 2'b10
  } esi_run_type;

endpackage

/* File: logic/esi_sync.sv */
// two-stage synchroniser for a vector of asynchronous pins
`timescale 1ns/1ps
module esi_sync #(
  parameter int unsigned WIDTH = 16,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      logic meta_q;
      logic stable_q;
      // the first stage feeds the second stage only
      always_ff @(posedge mclk) begin
        if (sys_rst) begin
          meta_q <= RST_VAL[gi];
          stable_q <= RST_VAL[gi];
        end else if (ce) begin
          meta_q <= async_in[gi];
          stable_q <= meta_q;
        end
      end
      assign sync_out[gi] = stable_q;
    end
  endgenerate

endmodule

/* File: logic/esi_blink.sv */
// divided-clock flash and single-flash pattern source for the run indicator
`timescale 1ns/1ps
module esi_blink #(
  parameter int unsigned FLASH_CYCLES = esi_pkg::FLASH_CYCLES
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  output logic flash_q,
  output logic single_q
);

  localparam int unsigned CNT_W = $clog2(FLASH_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(FLASH_CYCLES - 1);

  logic [CNT_W-1:0] cnt_q;
  logic [esi_pkg::PHASE_W-1:0] phase_q;
  wire tick = (cnt_q == CNT_LAST);
  wire phase_wrap = (phase_q == esi_pkg::PHASE_LAST);
  wire [esi_pkg::PHASE_W-1:0] phase_d = phase_wrap ? esi_pkg::PHASE_RST : phase_q + 1'b1;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cnt_q <= '0;
      phase_q <= esi_pkg::PHASE_RST;
      flash_q <= esi_pkg::PATTERN_RST;
      single_q <= esi_pkg::PATTERN_RST;
    end else if (ce) begin
      cnt_q <= tick ? '0 : cnt_q + 1'b1; // R19
      if (tick) begin
        phase_q <= phase_d;
        // six phases keep both patterns aligned to one 1.2 s frame
        flash_q <= ~phase_d[0]; // R19
        single_q <= (phase_d == esi_pkg::PHASE_RST); // R19
      end
    end
  end

  property p_flash_period;
    @(posedge mclk) disable iff (sys_rst)
      (ce && tick) |=> (flash_q != $past(flash_q));
  endproperty
  a_flash_period: assert property (p_flash_period) else $error("flash pattern did not toggle on tick"); // R19

endmodule

/* File: tb/esi_enc_model.sv */
// encoder and pulse generator model driving the channel 1 pins
`timescale 1ns/1ps
module esi_enc_model (
  input wire logic mclk,
  input wire logic single_ended,
  input wire logic [2:0] track,
  input wire logic [2:0] track_inv,
  input wire logic fault,
  input wire logic [2:0] broken,
  output logic [2:0] pin_trk,
  output logic [2:0] pin_inv,
  output logic fault_n,
  output logic [2:0] pin_wb
);
  logic toggle_q = 1'b0;
  always @(posedge mclk) begin
    toggle_q <= ~toggle_q;
  end
  assign pin_trk = track;
  // unconnected inverse legs float; a changing pattern stops a lucky settle hiding misuse
  assign pin_inv = single_ended ? {3{toggle_q}} : track_inv;
  // the fault output only pulls low; the pull-up holds the line high otherwise
  assign fault_n = fault ? 1'b0 : 1'b1;
  assign pin_wb = broken;
endmodule

/* File: tb/esi_top_tb.sv */
// self-checking bench for the channel status indicators
`timescale 1ns/1ps
module esi_top_tb;
  localparam int FC = 4;
  typedef struct packed {
    logic [2:0] ty;
    logic [2:0] trk;
    logic [2:0] inv;
    logic [2:0] wb;
    logic [2:0] en;
    logic [2:0] ty2;
    logic [2:0] en2;
    logic [3:0] misc;
  } esi_row_type;
  // misc bits: fault, supply, latch, gate
  esi_row_type rows [9] = '{
    '{3'h0, 3'h7, 3'h0, 3'h0, 3'h7, 3'h2, 3'h7, 4'h0},
    '{3'h0, 3'h7, 3'h5, 3'h7, 3'h5, 3'h0, 3'h2, 4'h8},
    '{3'h1, 3'h2, 3'h0, 3'h3, 3'h3, 3'h1, 3'h7, 4'h4},
    '{3'h1, 3'h0, 3'h0, 3'h0, 3'h7, 3'h3, 3'h7, 4'h2},
    '{3'h2, 3'h5, 3'h0, 3'h7, 3'h7, 3'h2, 3'h7, 4'h1},
    '{3'h3, 3'h2, 3'h7, 3'h7, 3'h7, 3'h4, 3'h7, 4'hf},
    '{3'h4, 3'h6, 3'h0, 3'h7, 3'h7, 3'h5, 3'h7, 4'h6},
    '{3'h5, 3'h3, 3'h0, 3'h0, 3'h0, 3'h1, 3'h0, 4'h9},
    '{3'h7, 3'h2, 3'h0, 3'h7, 3'h7, 3'h6, 3'h7, 4'h0}
  };
  logic [3:0] st_tab [6] = '{esi_pkg::ST_INIT, esi_pkg::ST_BOOT, esi_pkg::ST_STATE_PRE_OPERATIONAL,
                             esi_pkg::ST_STATE_SAFE_OPERATIONAL, esi_pkg::ST_OP, 4'h0};
  int on_tab [6] = '{0, 0, 6 * FC, 2 * FC, 12 * FC, 0};
  logic safe_tab [6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
  logic diag_tab [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic single_ended = 1'b0;
  logic [2:0] track = 3'h0;
  logic [2:0] track_inv = 3'h0;
  logic fault = 1'b0;
  logic [2:0] broken = 3'h0;
  logic supply = 1'b0;
  logic latch_input = 1'b0;
  logic gate_input = 1'b0;
  logic [2:0] ty1 = 3'h0;
  logic [2:0] ty2 = 3'h0;
  logic [2:0] en1 = 3'h0;
  logic [2:0] en2 = 3'h0;
  logic [3:0] slave_state = esi_pkg::ST_INIT;
  logic init_active = 1'b0;
  logic [2:0] pin_trk;
  logic [2:0] pin_inv;
  logic fault_n;
  logic [2:0] pin_wb;
  logic [2:0] led_track_green;
  logic [2:0] led_track_red;
  logic [2:0] led_ch2_track_red;
  logic [2:0] track_level;
  logic led_status_red;
  logic led_supply_green;
  logic led_latch_green;
  logic led_gate_green;
  logic led_run;
  logic led_diag;
  logic outputs_safe;
  logic count_dir;
  int mismatches = 0;
  int check_count = 0;
  int n;
  esi_row_type r;
  logic [2:0] l;
  logic [2:0] red;

  always #12.5 mclk = ~mclk;

  esi_enc_model enc (.mclk(mclk), .single_ended(single_ended), .track(track), .track_inv(track_inv),
    .fault(fault), .broken(broken), .pin_trk(pin_trk), .pin_inv(pin_inv), .fault_n(fault_n), .pin_wb(pin_wb));

  esi_top #(.FLASH_CYCLES(FC)) uut (.mclk(mclk), .sys_rst(sys_rst), .ce(ce),
    .track_a_input(pin_trk[0]), .track_b_input(pin_trk[1]), .track_c_zero_pulse_input(pin_trk[2]),
    .track_a_inverse(pin_inv[0]), .track_b_inverse(pin_inv[1]), .track_c_inverse(pin_inv[2]),
    .fault_status_n(fault_n), .encoder_supply_present(supply), .latch_input(latch_input),
    .gate_input(gate_input), .ch1_wire_break(pin_wb), .ch2_wire_break(pin_wb), .ch1_input_type(ty1),
    .ch1_err_det_a(en1[0]), .ch1_err_det_b(en1[1]), .ch1_err_det_c(en1[2]), .ch2_input_type(ty2),
    .ch2_err_det_a(en2[0]), .ch2_err_det_b(en2[1]), .ch2_err_det_c(en2[2]), .slave_state(slave_state),
    .init_active(init_active), .led_track_green(led_track_green), .led_track_red(led_track_red),
    .led_status_red(led_status_red), .led_supply_green(led_supply_green), .led_latch_green(led_latch_green),
    .led_gate_green(led_gate_green), .led_run(led_run), .led_diag(led_diag),
    .led_ch2_track_red(led_ch2_track_red), .outputs_safe(outputs_safe), .count_dir(count_dir),
    .track_level(track_level));

  task automatic chk_bit(input string name, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic chk_vec(input string name, input logic [2:0] exp, input logic [2:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic chk_cnt(input string name, input int exp, input int got);
    check_count++;
    if (got != exp) begin
      mismatches++;
      $display("BAD %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  task automatic chk_dark();
    chk_vec("led_track_green", 3'h0, led_track_green);
    chk_bit("led_latch_green", 1'b0, led_latch_green);
    chk_bit("led_run", 1'b0, led_run);
    chk_bit("outputs_safe", 1'b1, outputs_safe);
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // the whole sequence needs under a thousand cycles
  initial begin
    repeat (2000) @(posedge mclk);
    mismatches++;
    conclude();
  end

  initial begin
    repeat (7) @(posedge mclk);
    #1;
    chk_dark();
    @(posedge mclk);
    sys_rst <= 1'b0;
    foreach (rows[i]) begin
      r = rows[i];
      @(posedge mclk);
      ty1 <= r.ty;
      ty2 <= r.ty2;
      en1 <= r.en;
      en2 <= r.en2;
      single_ended <= (r.ty > 3'h1);
      track <= r.trk;
      track_inv <= r.inv;
      broken <= r.wb;
      {fault, supply, latch_input, gate_input} <= r.misc;
      repeat (5) @(posedge mclk);
      #1;
      l = (r.ty > 3'h1) ? r.trk : (r.trk & ~r.inv);
      red = (r.ty < 3'h2) ? (r.wb & r.en) : 3'h0;
      chk_vec("track_level", l, track_level);
      chk_vec("led_track_red", red, led_track_red);
      chk_vec("led_track_green", l & ~red, led_track_green);
      chk_vec("led_ch2_track_red", (r.ty2 < 3'h2) ? (r.wb & r.en2) : 3'h0, led_ch2_track_red);
      chk_bit("count_dir", ((r.ty == 3'h1) || (r.ty == 3'h3) || (r.ty == 3'h5)) & l[1], count_dir);
      chk_bit("led_status_red", r.misc[3], led_status_red);
      chk_bit("led_supply_green", r.misc[2], led_supply_green);
      chk_bit("led_latch_green", r.misc[1], led_latch_green);
      chk_bit("led_gate_green", r.misc[0], led_gate_green);
    end
    for (int k = 0; k < 6; k++) begin
      @(posedge mclk);
      slave_state <= st_tab[k];
      init_active <= (k == 0);
      repeat (4) @(posedge mclk);
      #1;
      chk_bit("outputs_safe", safe_tab[k], outputs_safe);
      chk_bit("led_diag", diag_tab[k], led_diag);
      n = 0;
      // whole pattern periods, so the count does not depend on the starting phase
      repeat (12 * FC) begin
        @(posedge mclk);
        #1;
        if (led_run === 1'b1)
          n++;
        else if (led_run !== 1'b0)
          n += 1000;
      end
      chk_cnt("led_run lit cycles", on_tab[k], n);
    end
    @(posedge mclk);
    ce <= 1'b0;
    latch_input <= 1'b1;
    repeat (6) @(posedge mclk);
    #1;
    chk_bit("led_latch_green frozen", 1'b0, led_latch_green);
    @(posedge mclk);
    ce <= 1'b1;
    slave_state <= esi_pkg::ST_OP;
    repeat (5) @(posedge mclk);
    #1;
    chk_bit("led_latch_green", 1'b1, led_latch_green);
    chk_bit("led_run", 1'b1, led_run);
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chk_dark();
    @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    chk_bit("led_status_red after reset", 1'b0, led_status_red);
    chk_bit("led_latch_green after reset", 1'b1, led_latch_green);
    chk_bit("led_run after reset", 1'b1, led_run);
    conclude();
  end
endmodule
